// File: src/serial_port.sv
// Purpose: Full-duplex byte serial port, master or slave, register driven
// Assumes: One core clock; pins are shared with a two-wire interface
// Notes:   Read data answers one cycle after the read strobe
// What this block does
// RULE_01: Eight bits shift out and eight shift in together per byte.
// RULE_02: Interface enable gives the pins to this port or to the two-wire side.
// RULE_03: MISO is input as master, output as slave; MOSI the reverse.
// RULE_04: Each byte travels most significant bit first on both lines.
// RULE_05: Serial clock is driven as master and only read as slave.
// RULE_06: One bit each way per clock period, eight periods per byte.
// RULE_07: Master clock rate, idle level and phase come from control bits.
// RULE_08: Slave reads the incoming clock with programmed polarity and phase.
// RULE_09: Data changes on one clock edge and is sampled on the other.
// RULE_10: The far party uses the same polarity and phase settings.
// RULE_11: Slave select is ignored as master, enables the port as slave.
// RULE_12: Slave select is active low; slave moves data only while low.
// RULE_13: With phase one, the far master may hold select low throughout.
// RULE_14: With phase zero, the far master frames each byte with select.
// RULE_15: As slave, reading the low rate bit returns the select pin level.
// RULE_16: Control register at F8H holds flags and mode bits, resets to 04H.
// RULE_17: Master clock is core clock over 2, 4, 8 or 16.
// RULE_18: Done flag sets at each byte end; cleared by write or data read.
// RULE_19: Collision flag sets on data write during a transfer.
// RULE_20: Master data write starts eight clocks; received byte then latched.
// RULE_21: Idle master clock output rests at the polarity level.

`timescale 1ns/1ns

module serial_port (
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire spi_port_pkg::sfr_req_s sfr_req,
   output logic [7:0]                 sfr_rdata,
   input  wire spi_port_pkg::pin_in_s  pin_in,
   output spi_port_pkg::pin_out_s     pin_out,
   output logic                       serial_owns_pins
);
   import spi_port_pkg::*;

   typedef struct packed {
      logic       done;
      logic       write_collision_flag;
      logic       en;
      logic       master;
      logic       clock_polarity_sel;
      logic       clock_phase_sel;
      logic [1:0] rate;
      xfer_e      xfer;
      logic       wait_ss;
      logic [7:0] rx_data;
      logic [7:0] txs;
      logic [7:0] rxs;
      logic       dout;
      logic       sclk;
      logic [2:0] hc;
      logic [3:0] edges;
      logic       sclk_prev;
      logic       ss_prev;
      logic [7:0] rdata;
   } state_s;

   state_s  st;
   state_s  next_st;
   pin_in_s pin_s;
   logic    done_set;
   logic    edge_now;
   logic    lead_now;
   logic    finish;
   logic    data_wr;
   logic    busy;

   pin_sync u_sync (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .pin_raw  (pin_in),
      .pin_safe (pin_s)
   );

   assign busy    = (st.xfer == ST_RUN);
   assign data_wr = sfr_req.wr && (sfr_req.addr == ADDR_DATA);

   always_comb begin
      next_st  = st;
      done_set = 1'b0;
      edge_now = 1'b0;
      lead_now = 1'b0;
      finish   = 1'b0;
      next_st.sclk_prev = pin_s.sclk;
      next_st.ss_prev   = pin_s.ss_n;
      // Master clock generator
      if (busy && st.en && st.master) begin
         if (st.hc == half_last(st.rate)) begin // RULE_17
            next_st.hc    = HC_ZERO;
            next_st.sclk  = ~st.sclk; // RULE_07
            next_st.edges = st.edges + EDGE_ONE;
            edge_now      = 1'b1;
            lead_now      = ~st.edges[0];
            finish        = (st.edges == EDGE_LAST); // RULE_06 RULE_20
         end else begin
            next_st.hc = st.hc + HC_ONE;
         end
      end
      // Slave follows the pin clock only while selected
      if (st.en && !st.master) begin
         if (!pin_s.ss_n) begin // RULE_11 RULE_12
            edge_now = (pin_s.sclk != st.sclk_prev);
            lead_now = edge_now && (st.sclk_prev == st.clock_polarity_sel); // RULE_08
            if (edge_now) begin
               next_st.xfer  = ST_RUN;
               next_st.edges = st.edges + EDGE_ONE;
               if (st.edges == EDGE_LAST) begin
                  if (st.clock_phase_sel) begin
                     finish = 1'b1;
                  end else begin
                     next_st.wait_ss = 1'b1;
                  end
               end
            end
            // Phase zero: the top bit already stands from the data write,
            // so a falling select must not shift it away
         end else if (!st.ss_prev) begin
            // Select released: byte ends if complete, else it is dropped
            finish          = st.wait_ss;
            next_st.xfer    = ST_IDLE;
            next_st.edges   = EDGE_ZERO;
            next_st.wait_ss = 1'b0;
         end
      end
      if (edge_now) begin
         if (lead_now == st.clock_phase_sel) begin // RULE_09
            next_st.dout = st.txs[7]; // RULE_04
            next_st.txs  = {st.txs[6:0], 1'b0};
         end else begin
            next_st.rxs = {st.rxs[6:0],
                           st.master ? pin_s.miso : pin_s.mosi}; // RULE_01
         end
      end
      if (finish) begin
         next_st.rx_data = next_st.rxs; // RULE_20
         next_st.xfer    = ST_IDLE;
         next_st.edges   = EDGE_ZERO;
         next_st.wait_ss = 1'b0;
         done_set        = 1'b1;
      end
      if (!st.en) begin
         next_st.xfer    = ST_IDLE;
         next_st.edges   = EDGE_ZERO;
         next_st.wait_ss = 1'b0;
      end
      // Software access
      if (data_wr) begin
         if (busy) begin
            next_st.write_collision_flag = 1'b1; // RULE_19
         end else begin
            next_st.txs = sfr_req.wdata;
            if (!st.clock_phase_sel) begin
               next_st.dout = sfr_req.wdata[7];
               next_st.txs  = {sfr_req.wdata[6:0], 1'b0};
            end
            if (st.en && st.master) begin
               next_st.xfer  = ST_RUN;
               next_st.hc    = HC_ZERO;
               next_st.edges = EDGE_ZERO;
               next_st.sclk  = st.clock_polarity_sel;
            end
         end
      end
      if (sfr_req.wr && (sfr_req.addr == ADDR_CTRL)) begin // RULE_16
         next_st.done   = sfr_req.wdata[BIT_DONE];
         next_st.write_collision_flag   = sfr_req.wdata[BIT_WRITE_COLLISION_FLAG];
         next_st.en     = sfr_req.wdata[BIT_EN];
         next_st.master = sfr_req.wdata[BIT_MASTER];
         next_st.clock_polarity_sel   = sfr_req.wdata[BIT_CLOCK_POLARITY_SEL];
         next_st.clock_phase_sel   = sfr_req.wdata[BIT_CLOCK_PHASE_SEL];
         next_st.rate   = {sfr_req.wdata[BIT_RATE_H],
                           sfr_req.wdata[BIT_RATE_L]};
      end
      if (sfr_req.rd && (sfr_req.addr == ADDR_DATA)) begin
         next_st.done = 1'b0; // RULE_18
      end
      // Hardware events win over a same-cycle clear
      if (done_set) begin
         next_st.done = 1'b1; // RULE_18
      end
      if (data_wr && busy) begin
         next_st.write_collision_flag = 1'b1;
      end
      next_st.rdata = 8'h00;
      if (sfr_req.rd) begin
         if (sfr_req.addr == ADDR_CTRL) begin
            next_st.rdata = {st.done, st.write_collision_flag, st.en, st.master, st.clock_polarity_sel,
                             st.clock_phase_sel, st.rate[1],
                             st.master ? st.rate[0] : pin_s.ss_n}; // RULE_15
         end else if (sfr_req.addr == ADDR_DATA) begin
            next_st.rdata = st.rx_data;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st         <= '0;
         st.done    <= CTRL_RESET[BIT_DONE];
         st.write_collision_flag    <= CTRL_RESET[BIT_WRITE_COLLISION_FLAG];
         st.en      <= CTRL_RESET[BIT_EN];
         st.master  <= CTRL_RESET[BIT_MASTER];
         st.clock_polarity_sel    <= CTRL_RESET[BIT_CLOCK_POLARITY_SEL];
         st.clock_phase_sel    <= CTRL_RESET[BIT_CLOCK_PHASE_SEL];
         st.rate    <= CTRL_RESET[BIT_RATE_H:BIT_RATE_L];
         st.rx_data <= DATA_RESET;
         st.sclk_prev <= 1'b1;
         st.ss_prev <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Enables are low while driving; all released when the pins are lent out
   always_comb begin
      pin_out.sclk      = busy ? st.sclk : st.clock_polarity_sel; // RULE_21
      pin_out.sclk_oe_n = !(st.en && st.master); // RULE_05 RULE_02
      pin_out.mosi      = st.dout;
      pin_out.mosi_oe_n = !(st.en && st.master); // RULE_03
      pin_out.miso      = st.dout;
      pin_out.miso_oe_n = !(st.en && !st.master && !pin_s.ss_n); // RULE_12
   end

   assign sfr_rdata        = st.rdata;
   assign serial_owns_pins = st.en; // RULE_02

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   AST_IDLE_LEVEL: assert property (st.en && st.master && !busy // RULE_21
      |-> pin_out.sclk == st.clock_polarity_sel) else $error("idle clock not at polarity");
   AST_MASTER_DIR: assert property (st.en && st.master // RULE_03
      |-> !pin_out.mosi_oe_n && pin_out.miso_oe_n && !pin_out.sclk_oe_n)
      else $error("master pin directions wrong");
   AST_LENT_OUT: assert property (!st.en // RULE_02
      |-> pin_out.sclk_oe_n && pin_out.mosi_oe_n && pin_out.miso_oe_n)
      else $error("pins driven while disabled");
   AST_SLAVE_SEL: assert property (st.en && !st.master && pin_s.ss_n // RULE_12
      |-> pin_out.miso_oe_n && pin_out.sclk_oe_n)
      else $error("slave drives while deselected");
   AST_COLLIDE: assert property (data_wr && busy // RULE_19
      |=> st.write_collision_flag) else $error("collision not flagged");
   AST_DONE_END: assert property ($fell(busy) && st.en && $past(st.master)
      |-> st.done) else $error("done not set at byte end"); // RULE_18
   AST_READ_CLR: assert property (sfr_req.rd && sfr_req.addr == ADDR_DATA
      && !done_set && !sfr_req.wr |=> !st.done)
      else $error("data read did not clear done"); // RULE_18
   AST_SS_READ: assert property (sfr_req.rd && sfr_req.addr == ADDR_CTRL
      && !st.master |=> sfr_rdata[BIT_RATE_L] == $past(pin_s.ss_n))
      else $error("select level not readable"); // RULE_15
   AST_HALF: assert property (busy && $past(busy) && st.master // RULE_17
      && $changed(st.sclk)
      |-> $past(st.hc) == half_last($past(st.rate)))
      else $error("clock half period wrong");
   AST_MSB: assert property (data_wr && !busy && !st.clock_phase_sel // RULE_04
      |=> st.dout == $past(sfr_req.wdata[7]))
      else $error("first bit is not the top bit");
   AST_FAST_BYTE: assert property ($rose(busy) && st.master // RULE_06
      && st.rate == 2'h0 && !data_wr |-> busy [*8] ##9 !busy)
      else $error("fast byte not sixteen cycles");

   COV_MASTER: cover property (st.master && $fell(busy) && st.done);
   COV_SLAVE: cover property (!st.master && done_set);
   COV_WRITE_COLLISION_FLAG: cover property (data_wr && busy);
   COV_SS_ABORT: cover property (!st.master && busy && pin_s.ss_n);

endmodule

// File: src/spi_port_pkg.sv
// Purpose: Shared constants and carriers for the byte-wide serial port
// Assumes: Special-register access by address with one-cycle strobes
// Notes:   Pin groups travel as packed structs

package spi_port_pkg;

   localparam logic [7:0] ADDR_CTRL  = 8'hF8;
   localparam logic [7:0] ADDR_DATA  = 8'hF7;
   localparam logic [7:0] CTRL_RESET = 8'h04;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // Control register bit positions
   localparam int BIT_DONE   = 7;
   localparam int BIT_WRITE_COLLISION_FLAG   = 6;
   localparam int BIT_EN     = 5;
   localparam int BIT_MASTER = 4;
   localparam int BIT_CLOCK_POLARITY_SEL   = 3;
   localparam int BIT_CLOCK_PHASE_SEL   = 2;
   localparam int BIT_RATE_H = 1;
   localparam int BIT_RATE_L = 0;

   localparam int          PIN_IN_W  = 4;
   localparam logic [3:0]  EDGE_LAST = 4'hF;
   localparam logic [3:0]  EDGE_ZERO = 4'h0;
   localparam logic [3:0]  EDGE_ONE  = 4'h1;
   localparam logic [2:0]  HC_ZERO   = 3'h0;
   localparam logic [2:0]  HC_ONE    = 3'h1;

   typedef enum logic {ST_IDLE, ST_RUN} xfer_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_s;

   typedef struct packed {
      logic sclk;
      logic mosi;
      logic miso;
      logic ss_n;
   } pin_in_s;

   typedef struct packed {
      logic sclk;
      logic sclk_oe_n;
      logic mosi;
      logic mosi_oe_n;
      logic miso;
      logic miso_oe_n;
   } pin_out_s;

   // Last core-clock count of one half serial-clock period
   function automatic logic [2:0] half_last(input logic [1:0] rate);
      logic [2:0] v;
      v = 3'h0;
      case (rate)
         2'h0: v = 3'h0;
         2'h1: v = 3'h1;
         2'h2: v = 3'h3;
         default: v = 3'h7;
      endcase
      return v;
   endfunction

endpackage

// File: src/pin_sync.sv
// Purpose: Two-stage synchroniser for the serial port pin inputs
// Assumes: Inputs are asynchronous to clk_sys
// Notes:   First stage feeds only the second stage

`timescale 1ns/1ns

module pin_sync (
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   input  wire spi_port_pkg::pin_in_s pin_raw,
   output spi_port_pkg::pin_in_s     pin_safe
);
   import spi_port_pkg::*;

   logic [PIN_IN_W-1:0] stage1;
   logic [PIN_IN_W-1:0] stage2;
   logic [PIN_IN_W-1:0] raw_bits;

   assign raw_bits = pin_raw;

   genvar i;
   generate
      for (i = 0; i < PIN_IN_W; i = i + 1) begin : g_bit
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               stage1[i] <= 1'b1;
               stage2[i] <= 1'b1;
            end else begin
               stage1[i] <= raw_bits[i];
               stage2[i] <= stage1[i];
            end
         end
      end
   endgenerate

   assign pin_safe = stage2;

endmodule

// File: testbench/spi_far_slave.sv
// Purpose: Far-side serial slave that answers the port in master mode
// Assumes: Armed before each byte, disarmed between bytes
// Notes:   Once its byte is spent the data line shows changing junk
`timescale 1ns/1ns
module spi_far_slave (
   input  wire logic       sclk,
   input  wire logic       mosi,
   input  wire logic       clock_phase_sel,
   input  wire logic       arm,
   input  wire logic [7:0] tx,
   output logic            miso,
   output logic [7:0]      rx
);
   logic [7:0] sh;
   logic       seen;
   int         cnt;
   initial begin
      cnt = 0;
      sh = 8'h00;
      seen = 1'b0;
      rx = 8'h00;
      miso = 1'b0;
   end
   // Odd edges lead; drive parity follows the phase setting
   // An arm change with no clock change loads the byte to send
   always @(sclk or arm) begin
      if (!arm || sclk === seen) begin
         cnt = 0;
         sh = tx;
      end else begin
         cnt = cnt + 1;
         if (cnt[0] == clock_phase_sel) begin
            if (cnt >= 2)
               sh = {sh[6:0], ~sh[0]};
         end else begin
            rx = {rx[6:0], mosi};
         end
      end
      seen = sclk;
      miso = (cnt < 16) ? sh[7] : ~miso;
   end
endmodule

// File: testbench/spi_master_slave_port_tb_top.sv
// Purpose: Self-checking bench for the byte-wide serial port
// Assumes: Master receive is only checked at slow rates (pin sync lag)
// Notes:   In slave mode the bench itself plays the far master
`timescale 1ns/1ns
module spi_master_slave_port_tb_top;
   import spi_port_pkg::*;
   logic       clk_sys;
   logic       rst;
   sfr_req_s   req;
   logic [7:0] rdata;
   pin_in_s    pin_in;
   pin_out_s   pin_out;
   logic       owns;
   logic       m_sclk;
   logic       m_mosi;
   logic       ss_n;
   logic       clock_phase_sel;
   logic       arm;
   logic [7:0] ftx;
   logic       far_miso;
   logic [7:0] far_rx;
   int         failures;
   int         tests_run;

   assign pin_in = '{sclk: pin_out.sclk_oe_n ? m_sclk : pin_out.sclk,
                     mosi: pin_out.mosi_oe_n ? m_mosi : pin_out.mosi,
                     miso: pin_out.miso_oe_n ? far_miso : pin_out.miso,
                     ss_n: ss_n};

   serial_port i_serial_port (
      .clk_sys          (clk_sys),
      .rst              (rst),
      .sfr_req          (req),
      .sfr_rdata        (rdata),
      .pin_in           (pin_in),
      .pin_out          (pin_out),
      .serial_owns_pins (owns)
   );
   spi_far_slave i_spi_far_slave (
      .sclk (pin_out.sclk),
      .mosi (pin_out.mosi),
      .clock_phase_sel (clock_phase_sel),
      .arm  (arm),
      .tx   (ftx),
      .miso (far_miso),
      .rx   (far_rx)
   );

   function automatic logic [7:0] ctl(input logic d, w,
                                      input logic [7:0] c, input logic b0);
      return {d, w, c[5:1], b0};
   endfunction
   function automatic logic [7:0] pins();
      return {4'h0, owns, pin_out.sclk_oe_n, pin_out.mosi_oe_n,
              pin_out.miso_oe_n};
   endfunction
   task automatic chk(input string n, input logic [7:0] e, s);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(negedge clk_sys);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge clk_sys);
      req.wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge clk_sys);
      req.rd = 1'b0;
      d = rdata;
   endtask
   task automatic results();
      $display("tests %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic mx(input logic [7:0] c);
      logic [7:0] t, d;
      logic       s, bad;
      int         n, e, g;
      t = 8'($urandom);
      ftx = 8'($urandom);
      clock_phase_sel = c[BIT_CLOCK_PHASE_SEL];
      arm = 1'b0;
      wr(ADDR_CTRL, c);
      chk("idle", {7'h0, c[BIT_CLOCK_POLARITY_SEL]}, {7'h0, pin_out.sclk});
      arm = 1'b1;
      ss_n = 1'($urandom);
      wr(ADDR_DATA, t);
      s = pin_out.sclk;
      n = 0;
      e = 0;
      g = 0;
      bad = 1'b0;
      fork
         wr(ADDR_DATA, ~t);
         while (e < 16 && n < 300) begin
            @(negedge clk_sys);
            n++;
            g++;
            if (pin_out.sclk !== s) begin
               e++;
               if (e > 1 && g != (1 << c[1:0]))
                  bad = 1'b1;
               s = pin_out.sclk;
               g = 0;
            end
         end
      join
      chk("edges", 8'h10, 8'(e));
      chk("rate", 8'h00, {7'h0, bad});
      repeat (3) @(negedge clk_sys);
      chk("rest", {7'h0, c[BIT_CLOCK_POLARITY_SEL]}, {7'h0, pin_out.sclk});
      rd(ADDR_CTRL, d);
      chk("flags", ctl(1, 1, c, c[0]), d);
      rd(ADDR_DATA, d);
      if (c[1])
         chk("master rx", ftx, d);
      chk("master tx", t, far_rx);
      rd(ADDR_CTRL, d);
      chk("done clear", ctl(0, 1, c, c[0]), d);
      wr(ADDR_CTRL, c);
      arm = 1'b0;
   endtask

   task automatic sx(input logic [7:0] c, input int ne);
      logic [7:0] t, m, got, d;
      int         b;
      t = 8'($urandom);
      m = 8'($urandom);
      // Deselect first, so the mode switch cannot look like a clock edge
      ss_n = 1'b1;
      m_sclk = c[BIT_CLOCK_POLARITY_SEL];
      wr(ADDR_CTRL, c);
      wr(ADDR_DATA, t);
      ss_n = 1'b0;
      m_mosi = m[7];
      b = c[BIT_CLOCK_PHASE_SEL] ? 0 : 1;
      got = 8'h00;
      repeat (4) @(negedge clk_sys);
      rd(ADDR_CTRL, d);
      chk("select low", ctl(0, 0, c, 0), d);
      chk("slave pins", 8'h0E, pins());
      repeat (4) @(negedge clk_sys);
      for (int k = 1; k <= ne; k++) begin
         if (k[0] != c[BIT_CLOCK_PHASE_SEL])
            got = {got[6:0], pin_out.miso};
         m_sclk = ~m_sclk;
         if (k[0] == c[BIT_CLOCK_PHASE_SEL]) begin
            m_mosi = (b < 8) ? m[7 - b] : ~m_mosi;
            b++;
         end
         repeat (8) @(negedge clk_sys);
      end
      ss_n = 1'b1;
      repeat (6) @(negedge clk_sys);
      rd(ADDR_CTRL, d);
      chk("slave ctrl", ctl(ne == 16, 0, c, 1), d);
      rd(ADDR_DATA, d);
      if (ne == 16) begin
         chk("slave rx", m, d);
         chk("slave tx", t, got);
      end
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // Whole run needs well under 20000 cycles
   initial begin
      repeat (50000) @(posedge clk_sys);
      failures++;
      results();
   end
   initial begin
      logic [7:0] d;
      rst = 1'b1;
      req = '0;
      m_sclk = 1'b0;
      m_mosi = 1'b0;
      ss_n = 1'b1;
      clock_phase_sel = 1'b0;
      arm = 1'b0;
      ftx = 8'h00;
      failures = 0;
      tests_run = 0;
      void'($urandom(32'hFDC4C69C));
      repeat (10) @(negedge clk_sys);
      rst = 1'b0;
      rd(ADDR_CTRL, d);
      // Reset leaves slave mode, so bit 0 reads back the select pin
      chk("ctrl reset", {CTRL_RESET[7:1], ss_n}, d);
      rd(ADDR_DATA, d);
      chk("data reset", DATA_RESET, d);
      rd(8'h5A, d);
      chk("unmapped", 8'h00, d);
      chk("pins off", 8'h07, pins());
      $display("test reset done");
      wr(ADDR_CTRL, 8'h30);
      chk("master pins", 8'h09, pins());
      for (int i = 0; i < 16; i++)
         mx({4'h3, i[3:0]});
      $display("test master done");
      for (int i = 0; i < 4; i++)
         sx({4'h2, i[1:0], 2'($urandom)}, 16);
      sx(8'h24, 4);
      sx(8'h20, 6);
      $display("test slave done");
      wr(ADDR_CTRL, 8'h00);
      chk("released", 8'h07, pins());
      $display("test release done");
      results();
   end
endmodule
